// ==== design/ipr_cfg.svh ====
`ifndef IPR_CFG_SVH
`define IPR_CFG_SVH
// register byte offsets on the apb bus
`define IPR_OFF_THREE   12'h000
`define IPR_OFF_FOUR    12'h004
`define IPR_OFF_FIVE    12'h008
`define IPR_OFF_SIX     12'h00c
`define IPR_OFF_SEVEN   12'h010
`define IPR_OFF_STATUS  12'h014
// implemented-bit masks per register
`define IPR_MASK_THREE  16'h0777
`define IPR_MASK_FOUR   16'h7077
`define IPR_MASK_FULL   16'h7777
// every implemented field resets to level 4
`define IPR_RST_FIELD   3'h4
`define IPR_RST_THREE   16'h0444
`define IPR_RST_FOUR    16'h4044
`define IPR_RST_FULL    16'h4444
// field positions (low bit) inside a register
`define IPR_POS_F3      12
`define IPR_POS_F2      8
`define IPR_POS_F1      4
`define IPR_POS_F0      0
`define IPR_LVL_OFF     3'h0
`define IPR_NUM_SRC     18
`endif

// ==== design/ipr_pkg.sv ====
package ipr_pkg;
    typedef logic [2:0]  ipr_level_t;
    typedef logic [15:0] ipr_reg_t;
    // apb request bundle
    typedef struct packed {
        logic        sel;
        logic        enable;
        logic        write;
        logic [11:0] addr;
        logic [31:0] wdata;
    } ipr_apb_req_t;
    typedef enum logic [2:0] {
        IPR_SEL_THREE,
        IPR_SEL_FOUR,
        IPR_SEL_FIVE,
        IPR_SEL_SIX,
        IPR_SEL_SEVEN,
        IPR_SEL_STATUS,
        IPR_SEL_NONE
    } ipr_sel_t;
endpackage

// ==== design/ipr_field_gate.sv ====
`timescale 1ns/1ps
`include "ipr_cfg.svh"
// per-source gate: a zero field blocks the request entirely
module ipr_field_gate
    import ipr_pkg::*;
(
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    // source side
    input  wire logic       req_i,
    input  wire ipr_level_t level_i,
    // arbiter side
    output logic            req_o,
    output ipr_level_t      level_o
);
    logic       req_nxt;
    ipr_level_t lvl_nxt;
    logic       req_r;
    ipr_level_t lvl_r;

    // level code passes straight through, 7 highest, 1 lowest
    always_comb
    begin
        req_nxt = req_i && (level_i != `IPR_LVL_OFF);
        lvl_nxt = req_nxt ? level_i : `IPR_LVL_OFF;
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            req_r <= 1'b0;
            lvl_r <= `IPR_LVL_OFF;
        end
        else
        begin
            req_r <= req_nxt;
            lvl_r <= lvl_nxt;
        end
    end

    assign req_o   = req_r;
    assign level_o = lvl_r;

    chk_gate_blocks_zero: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (level_i == `IPR_LVL_OFF) |=> !req_o)
        else $error("disabled source reached arbiter");
    chk_gate_level_pass: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (req_i && level_i != `IPR_LVL_OFF) |=> (req_o && level_o == $past(level_i)))
        else $error("level not passed through");
endmodule

// ==== design/ipr_regs.sv ====
`timescale 1ns/1ps
`include "ipr_cfg.svh"
// Functional notes
// - field code is the level directly; 111 is level 7, 001 is level 1.
// - a field of 000 disables its source; request never reaches the processor.
// - unimplemented bits ignore writes and read zero, incl. bits 15-11 of register three.
// - every implemented field resets to binary 100, level 4.
// - register three: dma ch1 at 10-8, adc one at 6-4, uart one tx at 2-0.
// - register four: pin change 14-12, i2c master 6-4, i2c slave 2-0.
// - register five: capture 8, capture 7, adc two, ext irq one, high to low.
// - register six: timer 4, compare 4, compare 3, dma ch2, high to low.
// - register seven: uart two tx, uart two rx, ext irq two, timer 5.
// - register four bits 11-7 always read zero.
module ipr_regs
    import ipr_pkg::*;
#(
    parameter int NSRC = `IPR_NUM_SRC
)
(
    // clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_n_i,
    // apb slave
    input  wire logic             psel_i,
    input  wire logic             penable_i,
    input  wire logic             pwrite_i,
    input  wire logic [11:0]      paddr_i,
    input  wire logic [31:0]      pwdata_i,
    input  wire logic [3:0]       pstrb_i,
    output logic      [31:0]      prdata_o,
    output logic                  pready_o,
    output logic                  pslverr_o,
    // raw source requests, index order as the level outputs
    input  wire logic [NSRC-1:0]  src_req_i,
    // gated requests and levels to the arbiter
    output logic      [NSRC-1:0]  gated_req_o,
    output logic      [3*NSRC-1:0] gated_level_o
);
    ipr_apb_req_t req;
    ipr_sel_t     sel;
    ipr_reg_t     three_r, four_r, five_r, six_r, seven_r;
    ipr_reg_t     three_nxt, four_nxt, five_nxt, six_nxt, seven_nxt;
    logic [31:0]  prdata_r, prdata_nxt;
    logic         pready_r, pready_nxt;
    logic         pslverr_r, pslverr_nxt;
    logic [4:0]   wr_count_r, wr_count_nxt;
    logic         access;
    logic [15:0]  wmask;
    ipr_level_t   lvl [NSRC];

    assign req = '{sel: psel_i, enable: penable_i, write: pwrite_i, addr: paddr_i, wdata: pwdata_i};

    // address decode, reused by read mux and write path
    function automatic ipr_sel_t decode(input logic [11:0] a);
        unique case (a)
            `IPR_OFF_THREE:  decode = IPR_SEL_THREE;
            `IPR_OFF_FOUR:   decode = IPR_SEL_FOUR;
            `IPR_OFF_FIVE:   decode = IPR_SEL_FIVE;
            `IPR_OFF_SIX:    decode = IPR_SEL_SIX;
            `IPR_OFF_SEVEN:  decode = IPR_SEL_SEVEN;
            `IPR_OFF_STATUS: decode = IPR_SEL_STATUS;
            default:         decode = IPR_SEL_NONE;
        endcase
    endfunction

    // masked merge keeps unimplemented bits at zero
    function automatic ipr_reg_t merge(input ipr_reg_t old, input logic [15:0] wd,
                                       input logic [15:0] be, input logic [15:0] impl);
        merge = ((old & ~be) | (wd & be)) & impl;
    endfunction

    assign sel    = decode(req.addr);
    // one-wait-state slave: answer two cycles after setup, pready is registered
    assign access = req.sel && req.enable && !pready_r;
    assign wmask  = {{8{pstrb_i[1]}}, {8{pstrb_i[0]}}};

    // register file next state
    always_comb
    begin
        three_nxt    = three_r;
        four_nxt     = four_r;
        five_nxt     = five_r;
        six_nxt      = six_r;
        seven_nxt    = seven_r;
        wr_count_nxt = wr_count_r;
        if (access && req.write)
        begin
            unique case (sel)
                IPR_SEL_THREE: three_nxt = merge(three_r, req.wdata[15:0], wmask, `IPR_MASK_THREE);
                IPR_SEL_FOUR:  four_nxt  = merge(four_r,  req.wdata[15:0], wmask, `IPR_MASK_FOUR);
                IPR_SEL_FIVE:  five_nxt  = merge(five_r,  req.wdata[15:0], wmask, `IPR_MASK_FULL);
                IPR_SEL_SIX:   six_nxt   = merge(six_r,   req.wdata[15:0], wmask, `IPR_MASK_FULL);
                IPR_SEL_SEVEN: seven_nxt = merge(seven_r, req.wdata[15:0], wmask, `IPR_MASK_FULL);
                IPR_SEL_STATUS,
                IPR_SEL_NONE:  three_nxt = three_r;
            endcase
            if (sel != IPR_SEL_NONE && sel != IPR_SEL_STATUS)
                wr_count_nxt = wr_count_r + 5'h01;
        end
    end

    // apb answer path; unmapped address gets pslverr and zero data
    always_comb
    begin
        pready_nxt  = access;
        pslverr_nxt = 1'b0;
        prdata_nxt  = prdata_r;
        if (access)
        begin
            pslverr_nxt = (sel == IPR_SEL_NONE) || (req.write && sel == IPR_SEL_STATUS);
            prdata_nxt  = 32'h0000_0000;
            if (!req.write)
            begin
                unique case (sel)
                    IPR_SEL_THREE:  prdata_nxt = {16'h0000, three_r & `IPR_MASK_THREE};
                    IPR_SEL_FOUR:   prdata_nxt = {16'h0000, four_r & `IPR_MASK_FOUR};
                    IPR_SEL_FIVE:   prdata_nxt = {16'h0000, five_r};
                    IPR_SEL_SIX:    prdata_nxt = {16'h0000, six_r};
                    IPR_SEL_SEVEN:  prdata_nxt = {16'h0000, seven_r};
                    IPR_SEL_STATUS: prdata_nxt = {9'h000, wr_count_r, gated_req_o};
                    IPR_SEL_NONE:   prdata_nxt = 32'h0000_0000;
                endcase
            end
        end
    end

    // state registers
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            three_r    <= `IPR_RST_THREE;
            four_r     <= `IPR_RST_FOUR;
            five_r     <= `IPR_RST_FULL;
            six_r      <= `IPR_RST_FULL;
            seven_r    <= `IPR_RST_FULL;
            wr_count_r <= 5'h00;
            prdata_r   <= 32'h0000_0000;
            pready_r   <= 1'b0;
            pslverr_r  <= 1'b0;
        end
        else
        begin
            three_r    <= three_nxt;
            four_r     <= four_nxt;
            five_r     <= five_nxt;
            six_r      <= six_nxt;
            seven_r    <= seven_nxt;
            wr_count_r <= wr_count_nxt;
            prdata_r   <= prdata_nxt;
            pready_r   <= pready_nxt;
            pslverr_r  <= pslverr_nxt;
        end
    end

    assign prdata_o  = prdata_r;
    assign pready_o  = pready_r;
    assign pslverr_o = pslverr_r;

    // source index to field mapping, register three first
    always_comb
    begin
        lvl[0]  = three_r[`IPR_POS_F2 +: 3]; // dma_ch1_done_level
        lvl[1]  = three_r[`IPR_POS_F1 +: 3]; // adc_one_done_level
        lvl[2]  = three_r[`IPR_POS_F0 +: 3]; // uart_one_tx_level
        lvl[3]  = four_r[`IPR_POS_F3 +: 3];  // pin_change_level
        lvl[4]  = four_r[`IPR_POS_F1 +: 3];  // i2c_one_master_level
        lvl[5]  = four_r[`IPR_POS_F0 +: 3];  // i2c_one_slave_level
        lvl[6]  = five_r[`IPR_POS_F3 +: 3];  // capture_eight_level
        lvl[7]  = five_r[`IPR_POS_F2 +: 3];  // capture_seven_level
        lvl[8]  = five_r[`IPR_POS_F1 +: 3];  // adc_two_done_level
        lvl[9]  = five_r[`IPR_POS_F0 +: 3];  // ext_irq_one_level
        lvl[10] = six_r[`IPR_POS_F3 +: 3];   // timer_four_level
        lvl[11] = six_r[`IPR_POS_F2 +: 3];   // compare_four_level
        lvl[12] = six_r[`IPR_POS_F1 +: 3];   // compare_three_level
        lvl[13] = six_r[`IPR_POS_F0 +: 3];   // dma_ch2_done_level
        lvl[14] = seven_r[`IPR_POS_F3 +: 3]; // uart_two_tx_level
        lvl[15] = seven_r[`IPR_POS_F2 +: 3]; // uart_two_rx_level
        lvl[16] = seven_r[`IPR_POS_F1 +: 3]; // ext_irq_two_level
        lvl[17] = seven_r[`IPR_POS_F0 +: 3]; // timer_five_level
    end

    // one gate per source; output is registered inside the gate
    for (genvar g = 0; g < NSRC; g++)
    begin : g_gate
        ipr_field_gate u_gate (
            .clk_i   (clk_i),
            .rst_n_i (rst_n_i),
            .req_i   (src_req_i[g]),
            .level_i (lvl[g]),
            .req_o   (gated_req_o[g]),
            .level_o (gated_level_o[3*g +: 3])
        );
    end

    chk_reset_level_four: assert property (@(posedge clk_i)
        $rose(rst_n_i) |-> (three_r == `IPR_RST_THREE && four_r == `IPR_RST_FOUR && five_r == `IPR_RST_FULL
            && six_r == `IPR_RST_FULL && seven_r == `IPR_RST_FULL))
        else $error("field not at level 4 after reset");
    chk_three_upper_zero: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (pready_o && !$past(pwrite_i) && $past(paddr_i) == `IPR_OFF_THREE) |-> prdata_o[15:11] == 5'h00)
        else $error("register three upper bits not zero");
    chk_four_hole_zero: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (pready_o && !$past(pwrite_i) && $past(paddr_i) == `IPR_OFF_FOUR) |-> prdata_o[11:7] == 5'h00)
        else $error("register four bits 11-7 not zero");
    chk_write_lands: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (access && req.write && sel == IPR_SEL_SIX && pstrb_i[1:0] == 2'b11)
            |=> six_r == ($past(pwdata_i[15:0]) & `IPR_MASK_FULL))
        else $error("write to register six lost");
    chk_read_one_wait: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (psel_i && !penable_i) ##1 (psel_i && penable_i) |=> pready_o)
        else $error("pready not after one wait");
    chk_seven_field_map: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        gated_req_o[17] |-> gated_level_o[53:51] == $past(seven_r[2:0]))
        else $error("timer five level mapped wrong");

    // register three keeps only its three fields
    chk_three_store_mask: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (three_r & ~`IPR_MASK_THREE) == 16'h0000)
        else $error("register three holds unimplemented bits");
    // register four hole must never fill, though reads mask it off
    chk_four_store_mask: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (four_r & ~`IPR_MASK_FOUR) == 16'h0000)
        else $error("register four holds unimplemented bits");
    // spacer bits of register five stay clear
    chk_five_store_mask: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (five_r & ~`IPR_MASK_FULL) == 16'h0000)
        else $error("register five holds unimplemented bits");
    // spacer bits of register six stay clear
    chk_six_store_mask: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (six_r & ~`IPR_MASK_FULL) == 16'h0000)
        else $error("register six holds unimplemented bits");
    // spacer bits of register seven stay clear
    chk_seven_store_mask: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (seven_r & ~`IPR_MASK_FULL) == 16'h0000)
        else $error("register seven holds unimplemented bits");

    // full-strobe write to register three lands masked
    chk_write_three: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (access && req.write && sel == IPR_SEL_THREE && pstrb_i[1:0] == 2'b11)
            |=> three_r == ($past(pwdata_i[15:0]) & `IPR_MASK_THREE))
        else $error("write to register three lost");
    // full-strobe write to register four lands masked
    chk_write_four: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (access && req.write && sel == IPR_SEL_FOUR && pstrb_i[1:0] == 2'b11)
            |=> four_r == ($past(pwdata_i[15:0]) & `IPR_MASK_FOUR))
        else $error("write to register four lost");
    // full-strobe write to register five lands masked
    chk_write_five: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (access && req.write && sel == IPR_SEL_FIVE && pstrb_i[1:0] == 2'b11)
            |=> five_r == ($past(pwdata_i[15:0]) & `IPR_MASK_FULL))
        else $error("write to register five lost");
    // full-strobe write to register seven lands masked
    chk_write_seven: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (access && req.write && sel == IPR_SEL_SEVEN && pstrb_i[1:0] == 2'b11)
            |=> seven_r == ($past(pwdata_i[15:0]) & `IPR_MASK_FULL))
        else $error("write to register seven lost");

    // low-byte-only write must leave the upper fields alone
    chk_strobe_low_byte: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (access && req.write && sel == IPR_SEL_SIX && pstrb_i[1:0] == 2'b01)
            |=> six_r[15:8] == $past(six_r[15:8]))
        else $error("masked high byte of register six changed");
    // high-byte-only write must leave the lower fields alone
    chk_strobe_high_byte: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (access && req.write && sel == IPR_SEL_THREE && pstrb_i[1:0] == 2'b10)
            |=> three_r[7:0] == $past(three_r[7:0]))
        else $error("masked low byte of register three changed");

    // fields only move on an accepted write, never from reads or idle
    chk_no_stray_write: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !(access && req.write)
            |=> {three_r, four_r, five_r, six_r, seven_r} == $past({three_r, four_r, five_r, six_r, seven_r}))
        else $error("priority register changed without a write");

    // refused writes flag an error and change nothing
    chk_refused_write: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (access && req.write && (sel == IPR_SEL_NONE || sel == IPR_SEL_STATUS))
            |=> (pslverr_o && {three_r, four_r, five_r, six_r, seven_r} == $past({three_r, four_r, five_r, six_r, seven_r})))
        else $error("refused write altered a register");

    // ready is a single-cycle answer, so no transfer is acked twice
    chk_pready_pulse: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        pready_o |=> !pready_o)
        else $error("pready held longer than one cycle");
    // error is only meaningful alongside ready
    chk_err_with_ready: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        pslverr_o |-> pready_o)
        else $error("pslverr without pready");

    // read of register three returns the stored word
    chk_read_three: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (access && !req.write && sel == IPR_SEL_THREE) |=> prdata_o == {16'h0000, $past(three_r)})
        else $error("register three read mismatch");
    // read of register four returns the stored word
    chk_read_four: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (access && !req.write && sel == IPR_SEL_FOUR) |=> prdata_o == {16'h0000, $past(four_r)})
        else $error("register four read mismatch");
    // read of register five returns the stored word
    chk_read_five: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (access && !req.write && sel == IPR_SEL_FIVE) |=> prdata_o == {16'h0000, $past(five_r)})
        else $error("register five read mismatch");
    // read of register six returns the stored word
    chk_read_six: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (access && !req.write && sel == IPR_SEL_SIX) |=> prdata_o == {16'h0000, $past(six_r)})
        else $error("register six read mismatch");
    // read of register seven returns the stored word
    chk_read_seven: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (access && !req.write && sel == IPR_SEL_SEVEN) |=> prdata_o == {16'h0000, $past(seven_r)})
        else $error("register seven read mismatch");

    // dma channel one level comes from bits 10-8 of register three
    chk_dma_one_map: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        gated_req_o[0] |-> gated_level_o[2:0] == $past(three_r[`IPR_POS_F2 +: 3]))
        else $error("dma channel one level mapped wrong");
    // pin change level comes from the top field of register four
    chk_pin_change_map: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        gated_req_o[3] |-> gated_level_o[11:9] == $past(four_r[`IPR_POS_F3 +: 3]))
        else $error("pin change level mapped wrong");
    // capture eight level comes from the top field of register five
    chk_capture_eight_map: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        gated_req_o[6] |-> gated_level_o[20:18] == $past(five_r[`IPR_POS_F3 +: 3]))
        else $error("capture eight level mapped wrong");
    // timer four level comes from the top field of register six
    chk_timer_four_map: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        gated_req_o[10] |-> gated_level_o[32:30] == $past(six_r[`IPR_POS_F3 +: 3]))
        else $error("timer four level mapped wrong");
    // uart two transmit level comes from the top field of register seven
    chk_uart_tx_map: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        gated_req_o[14] |-> gated_level_o[44:42] == $past(seven_r[`IPR_POS_F3 +: 3]))
        else $error("uart two transmit level mapped wrong");

    // a cleared field silences its source at the arbiter
    chk_zero_blocks_dma: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (three_r[`IPR_POS_F2 +: 3] == `IPR_LVL_OFF) |=> !gated_req_o[0])
        else $error("disabled dma channel one reached arbiter");

    // outputs stay quiet while reset is held
    chk_reset_outputs: assert property (@(posedge clk_i)
        !rst_n_i |-> (!pready_o && !pslverr_o && gated_req_o == '0 && prdata_o == 32'h0000_0000))
        else $error("output active during reset");

    // unmapped read answers zero with an error
    chk_unmapped_read_zero: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (access && !req.write && sel == IPR_SEL_NONE) |=> (prdata_o == 32'h0000_0000 && pslverr_o))
        else $error("unmapped read returned data");
endmodule

// ==== verif/interrupt_priority_regs_3_to_7_tb_top.sv ====
`timescale 1ns/1ps
`include "ipr_cfg.svh"
module interrupt_priority_regs_3_to_7_tb_top;
    logic        clk_i;
    logic        rst_n_i;
    logic        psel_i;
    logic        penable_i;
    logic        pwrite_i;
    logic [11:0] paddr_i;
    logic [31:0] pwdata_i;
    logic [3:0]  pstrb_i;
    logic [31:0] prdata_o;
    logic        pready_o;
    logic        pslverr_o;
    logic [17:0] src_req_i;
    logic [17:0] gated_req_o;
    logic [53:0] gated_level_o;
    int          mismatches;
    int          checks_done;
    int          cyc;
    int          src_reg [18];
    int          src_pos [18];
    logic [15:0] exp_r [5];
    logic [15:0] msk [5] = '{`IPR_MASK_THREE, `IPR_MASK_FOUR, `IPR_MASK_FULL, `IPR_MASK_FULL, `IPR_MASK_FULL};
    logic [15:0] pat [5] = '{16'h0712, 16'h3045, 16'h6701, 16'h2345, 16'h0617};
    logic [11:0] off [5] = '{`IPR_OFF_THREE, `IPR_OFF_FOUR, `IPR_OFF_FIVE, `IPR_OFF_SIX, `IPR_OFF_SEVEN};
    logic [31:0] rd;
    logic        er;

    ipr_regs u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i),
        .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i), .prdata_o(prdata_o),
        .pready_o(pready_o), .pslverr_o(pslverr_o), .src_req_i(src_req_i), .gated_req_o(gated_req_o),
        .gated_level_o(gated_level_o));

    // free-running 40 mhz clock
    initial
    begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end

    task automatic cmp(input logic [63:0] got, input logic [63:0] want, input string what);
        checks_done++;
        if (got !== want)
        begin
            mismatches++;
            $display("BAD %0t %s got %h want %h", $time, what, got, want);
        end
    endtask

    // one apb transfer; request held until pready is seen high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
        @(posedge clk_i);
        psel_i    <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i  <= wr;
        paddr_i   <= a;
        pwdata_i  <= d;
        pstrb_i   <= s;
        @(posedge clk_i);
        penable_i <= 1'b1;
        // no local limit: a hung slave is caught by the cycle guard
        do
        begin
            @(posedge clk_i);
        end
        while (pready_o !== 1'b1);
        rd = prdata_o;
        er = pslverr_o;
        psel_i    <= 1'b0;
        penable_i <= 1'b0;
    endtask

    task automatic rd_all();
        for (int k = 0; k < 5; k++)
        begin
            apb(1'b0, off[k], 32'h0, 4'h0);
            cmp(rd, {16'h0, exp_r[k]}, "read value");
            cmp(er, 1'b0, "read error flag");
        end
    endtask

    // model keeps only implemented bits of enabled bytes
    task automatic wr(input int k, input logic [15:0] d, input logic [3:0] s);
        logic [15:0] bm;
        bm = {{8{s[1]}}, {8{s[0]}}} & msk[k];
        apb(1'b1, off[k], {16'hffff, d}, s);
        cmp(er, 1'b0, "write error flag");
        exp_r[k] = (exp_r[k] & ~bm) | (d & bm);
    endtask

    task automatic gate(input logic [17:0] req);
        logic [17:0] eq;
        logic [53:0] el;
        logic [2:0]  lv;
        eq = '0;
        el = '0;
        for (int i = 0; i < 18; i++)
        begin
            lv = 3'(exp_r[src_reg[i]] >> src_pos[i]);
            eq[i] = req[i] && (lv != 3'h0);
            el[3*i+:3] = eq[i] ? lv : 3'h0;
        end
        @(posedge clk_i);
        src_req_i <= req;
        repeat (2) @(posedge clk_i);
        cmp(gated_req_o, eq, "gated request");
        cmp(gated_level_o, el, "gated level");
    endtask

    task automatic do_reset();
        rst_n_i <= 1'b0;
        repeat (6) @(posedge clk_i);
        rst_n_i <= 1'b1;
        exp_r = '{`IPR_RST_THREE, `IPR_RST_FOUR, `IPR_RST_FULL, `IPR_RST_FULL, `IPR_RST_FULL};
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // hang guard, well above the few hundred cycles the tests need
    always @(posedge clk_i)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            mismatches++;
            results();
        end
    end

    initial
    begin
        {rst_n_i, psel_i, penable_i, pwrite_i} = 4'h0;
        {paddr_i, pwdata_i, pstrb_i, src_req_i} = '0;
        // source index table derived from implemented fields, high field first
        for (int k = 0, i = 0; k < 5; k++)
            for (int f = 3; f >= 0; f--)
                if (((msk[k] >> (4 * f)) & 16'h7) != 16'h0)
                begin
                    src_reg[i] = k;
                    src_pos[i] = 4 * f;
                    i++;
                end
        do_reset();
        rd_all();
        gate(18'h3ffff);
        for (int k = 0; k < 5; k++)
            wr(k, 16'hffff, 4'h3);
        rd_all();
        gate(18'h3ffff);
        for (int k = 0; k < 5; k++)
            wr(k, pat[k] | ~msk[k], 4'h3);
        rd_all();
        gate(18'h3ffff);
        gate(18'h2aaaa);
        gate(18'h00000);
        wr(3, 16'h7777, 4'h1);
        wr(0, 16'h0000, 4'h2);
        rd_all();
        gate(18'h3ffff);
        apb(1'b0, 12'h018, 32'h0, 4'h0);
        cmp(er, 1'b1, "unmapped read error");
        cmp(rd, 32'h0, "unmapped read data");
        apb(1'b1, 12'h020, 32'hffff, 4'h3);
        cmp(er, 1'b1, "unmapped write error");
        apb(1'b1, `IPR_OFF_STATUS, 32'hffff, 4'h3);
        cmp(er, 1'b1, "status write error");
        rd_all();
        do_reset();
        rd_all();
        gate(18'h3ffff);
        results();
    end
endmodule
